/* File: hdl/cir_ctrl.sv */
// Cascaded interrupt controller pair with legacy cascade redirect
// Behaviour
// - Peripheral-bus requests are level sensitive and expansion-bus requests edge sensitive.
// - A service done command clears the in-service bit of the level being serviced.
// - A service done command is acted on whether the request line is high or low.
// - A level request still high at service done becomes pending again.
// - The bus cascade request line is routed in hardware to the secondary redirected input.
// - The redirected line gives vector 71 hex; vector 0a hex is never issued, as level 2 always takes a slave vector.
// - An in-progress latch reads as one I/O bit and is cleared by the read unless an acknowledge sets it in the same cycle.
// - Writes to the legacy sharing reset ports are harmless.
`timescale 1ns/1ps
`default_nettype none
module cir_ctrl
    import cir_pkg::*;
#(
    parameter logic [15:0] LEVEL_SENSE = 16'hff00
)(
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [15:0] irq_in,
    input  wire logic        cascade_request_line,
    input  wire logic        int_ack,
    input  wire logic        service_done_master,
    input  wire logic        service_done_slave,
    input  wire logic        io_rd,
    input  wire logic        io_wr,
    input  wire logic [11:0] io_addr,
    output logic             int_req,
    output logic [7:0]       int_vector,
    output logic [15:0]      in_service,
    output logic [15:0]      pending,
    output logic             io_rd_data
);
    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (CIR_LINES != 8)
    begin : g_bad_lines
        $error("Only two eight-line controllers supported");
    end

    logic [15:0] req;
    logic [15:0] req_prev;
    logic [15:0] next_req_prev;
    logic [15:0] next_pending;
    logic [15:0] next_in_service;
    logic [7:0]  next_int_vector;
    logic        next_int_req;
    logic        latch;
    logic        next_latch;
    logic        next_io_rd_data;
    logic [3:0]  slave_top;
    logic [3:0]  pick;
    logic        slave_out;
    logic        found;
    logic        slave_found;

    // ------------------------------------------------------------
    // Request routing
    // ------------------------------------------------------------
    always_comb
    begin
        req = irq_in;
        req[{1'b0, CIR_CASCADE_LVL}] = 1'b0;
        req[{1'b1, CIR_REDIRECT_LVL}] = cascade_request_line;
    end

    // ------------------------------------------------------------
    // Priority and next state
    // ------------------------------------------------------------
    always_comb
    begin
        slave_found = 1'b0;
        slave_top   = 4'h0;
        for (int i = 15; i >= 8; i--)
        begin
            if (pending[i] && !in_service[i])
            begin
                slave_found = 1'b1;
                slave_top   = 4'(i);
            end
        end
        slave_out = slave_found || (|in_service[15:8]);
        found = 1'b0;
        pick  = 4'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (i == 2)
            begin
                if (slave_found && !in_service[2])
                begin
                    found = 1'b1;
                    pick  = slave_top;
                end
            end
            else if (pending[i] && !in_service[i])
            begin
                found = 1'b1;
                pick  = 4'(i);
            end
        end
        next_req_prev   = req;
        next_pending    = pending;
        next_in_service = in_service;
        next_int_vector = int_vector;
        next_latch      = latch;
        next_io_rd_data = 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            if (LEVEL_SENSE[i])
                next_pending[i] = req[i];
            else if (req[i] && !req_prev[i])
                next_pending[i] = 1'b1;
        end
        // Lowest in-service level is the one being served
        if (service_done_master)
        begin
            for (int i = 0; i < 8; i++)
            begin
                if (in_service[i])
                    next_in_service[i] = 1'b0;
                if (in_service[i])
                    break;
            end
        end
        if (service_done_slave)
        begin
            for (int i = 8; i < 16; i++)
            begin
                if (in_service[i])
                    next_in_service[i] = 1'b0;
                if (in_service[i])
                    break;
            end
        end
        if (int_ack && found)
        begin
            next_in_service[pick] = 1'b1;
            // A fresh edge in the acknowledge cycle stays pending
            if (!LEVEL_SENSE[pick] && !(req[pick] && !req_prev[pick]))
                next_pending[pick] = 1'b0;
            if (pick[3])
            begin
                next_in_service[{1'b0, CIR_CASCADE_LVL}] = 1'b1;
                next_int_vector = CIR_SLAVE_BASE + {5'h0, pick[2:0]};
            end
            else
                next_int_vector = CIR_MASTER_BASE + {5'h0, pick[2:0]};
            next_latch = 1'b1;
        end
        if (io_rd && io_addr == CIR_LATCH_PORT)
        begin
            next_io_rd_data = latch;
            if (!(int_ack && found))
                next_latch = 1'b0;
        end
        // Sharing reset port writes deliberately decode to nothing
        next_int_req = found && !(int_ack) && (slave_out || |pending[7:0]);
    end

    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            req_prev   <= 16'h0000;
            pending    <= 16'h0000;
            in_service <= 16'h0000;
            int_vector <= 8'h00;
            int_req    <= 1'b0;
            latch      <= 1'b0;
            io_rd_data <= 1'b0;
        end
        else
        begin
            req_prev   <= next_req_prev;
            pending    <= next_pending;
            in_service <= next_in_service;
            int_vector <= next_int_vector;
            int_req    <= next_int_req;
            latch      <= next_latch;
            io_rd_data <= next_io_rd_data;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    AST_EDGE_PEND: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!LEVEL_SENSE[3] && irq_in[3] && !$past(irq_in[3])) |=> pending[3])
        else $error("Edge request not latched");
    AST_LEVEL_FOLLOW: assert property (@(posedge sys_clk) disable iff (!rst_b)
        irq_in[11] |=> pending[11])
        else $error("Level request not pending");
    AST_DONE_CLEARS: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (service_done_master && in_service[0] && !int_ack) |=> !in_service[0])
        else $error("Service done did not clear");
    AST_DONE_ANY_LEVEL: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (service_done_slave && in_service[15:8] == 8'h02 && !int_ack) |=>
        in_service[15:8] == 8'h00)
        else $error("Service done ignored");
    AST_REDIRECT: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (cascade_request_line && !$past(cascade_request_line)) |=> pending[9])
        else $error("Cascade request not redirected");
    AST_LINE9_MASKED: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (LEVEL_SENSE[9] && irq_in[9] && !cascade_request_line) |=> !pending[9])
        else $error("Bus level nine not masked");
    AST_VEC71: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (int_ack && found && pick == 4'h9) |=> int_vector == CIR_REDIRECT_VEC)
        else $error("Wrong redirected vector");
    AST_LATCH_RD: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (io_rd && io_addr == CIR_LATCH_PORT && !int_ack) |=> !latch)
        else $error("Latch not cleared by read");
    AST_SHARE_WR: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (io_wr && ((io_addr & CIR_SHARE_MASK) == CIR_SHARE_PORT_A
         || (io_addr & CIR_SHARE_MASK) == CIR_SHARE_PORT_B) && !int_ack
         && !service_done_master && !service_done_slave) |=> $stable(in_service))
        else $error("Share port write disturbed state");
    AST_CASCADE_IS: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (int_ack && found && pick[3]) |=> in_service[2])
        else $error("Cascade in-service not set");
endmodule : cir_ctrl
`default_nettype wire

/* File: hdl/cir_pkg.sv */
// Constants for the cascaded interrupt redirect block
package cir_pkg;
    localparam int          CIR_LINES        = 8;
    localparam int          CIR_LVL_W        = 3;
    localparam int          CIR_LVL_W_ALL    = 4;
    localparam logic [2:0]  CIR_CASCADE_LVL  = 3'h2;
    localparam logic [2:0]  CIR_REDIRECT_LVL = 3'h1;
    localparam logic [7:0]  CIR_MASTER_BASE  = 8'h08;
    localparam logic [7:0]  CIR_SLAVE_BASE   = 8'h70;
    localparam logic [7:0]  CIR_SHARED_VEC   = 8'h0a;
    localparam logic [7:0]  CIR_REDIRECT_VEC = 8'h71;
    localparam logic [11:0] CIR_SHARE_PORT_A = 12'h2f0;
    localparam logic [11:0] CIR_SHARE_PORT_B = 12'h6f0;
    localparam logic [11:0] CIR_SHARE_MASK   = 12'hff8;
    localparam logic [11:0] CIR_LATCH_PORT   = 12'h0ff;
    localparam int          CIR_LATCH_BIT    = 0;
    typedef enum logic [1:0] {CIR_IDLE = 2'b00, CIR_ACK = 2'b01} cir_state_t;
endpackage : cir_pkg

/* File: verif/cir_host.sv */
// Host processor model: acknowledge and service done handshakes
`timescale 1ns/1ps
`default_nettype none
module cir_host (
    input  wire logic       sys_clk,
    input  wire logic       int_req,
    input  wire logic [7:0] int_vector,
    output logic            int_ack,
    output logic            service_done_master,
    output logic            service_done_slave
);
    initial
    begin
        int_ack             = 1'b0;
        service_done_master = 1'b0;
        service_done_slave  = 1'b0;
    end
    task automatic take(output logic [7:0] vec, output logic ok);
        ok = 1'b0;
        for (int i = 0; i < 20 && !ok; i++)
        begin
            @(posedge sys_clk);
            #1;
            ok = (int_req === 1'b1);
        end
        int_ack = ok;
        @(posedge sys_clk);
        #1;
        int_ack = 1'b0;
        vec     = int_vector;
    endtask : take
    // Caller may leave the source high; only the service done lines are pulsed
    task automatic done(input logic slave);
        @(posedge sys_clk);
        #1;
        if (slave)
        begin
            service_done_slave = 1'b1;
            @(posedge sys_clk);
            #1;
            service_done_slave = 1'b0;
        end
        service_done_master = 1'b1;
        @(posedge sys_clk);
        #1;
        service_done_master = 1'b0;
        @(posedge sys_clk);
        #1;
    endtask : done
endmodule : cir_host
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the cascaded interrupt redirect block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import cir_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_b   = 1'b0;
    logic [15:0] irq_in  = 16'h0000;
    logic        casc    = 1'b0;
    logic        io_rd   = 1'b0;
    logic        io_wr   = 1'b0;
    logic [11:0] io_addr = 12'h000;
    logic        ack, done_m, done_s, int_req, rd_data, ok;
    logic [7:0]  int_vector, vec;
    logic [15:0] in_service, pending;
    int          err_total  = 0;
    int          n_compared = 0;
    logic [3:0]  row_lvl [4] = '{4'h3, 4'h5, 4'h7, 4'hc};
    logic [7:0]  row_vec [4] = '{8'h0b, 8'h0d, 8'h0f, 8'h74};
    always #4 sys_clk = ~sys_clk;
    cir_ctrl dut (.sys_clk(sys_clk), .rst_b(rst_b), .irq_in(irq_in),
        .cascade_request_line(casc), .int_ack(ack), .service_done_master(done_m),
        .service_done_slave(done_s), .io_rd(io_rd), .io_wr(io_wr), .io_addr(io_addr),
        .int_req(int_req), .int_vector(int_vector), .in_service(in_service),
        .pending(pending), .io_rd_data(rd_data));
    cir_host host (.sys_clk(sys_clk), .int_req(int_req), .int_vector(int_vector),
        .int_ack(ack), .service_done_master(done_m), .service_done_slave(done_s));
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic take_chk(input int lvl, input logic [7:0] ev);
        host.take(vec, ok);
        chk("request seen", 16'h1, {15'h0, ok});
        chk("int_vector", {8'h0, ev}, {8'h0, vec});
        chk("in_service", (16'h1 << lvl) | (lvl > 7 ? 16'h4 : 16'h0), in_service);
    endtask : take_chk
    task automatic io(input logic wr, input logic [11:0] a, input logic exp);
        io_addr = a;
        io_wr   = wr;
        io_rd   = !wr;
        @(posedge sys_clk);
        #1;
        io_wr = 1'b0;
        io_rd = 1'b0;
        if (!wr)
            chk("io_rd_data", {15'h0, exp}, {15'h0, rd_data});
        @(posedge sys_clk);
        #1;
    endtask : io
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    initial
    begin
        #100000;
        err_total++;
        $display("[ERR] watchdog expected done seen hang");
        finish_test();
    end
    initial
    begin
        repeat (5) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        @(posedge sys_clk);
        #1;
        for (int i = 0; i < 4; i++)
        begin
            irq_in[row_lvl[i]] = 1'b1;
            take_chk(row_lvl[i], row_vec[i]);
            irq_in[row_lvl[i]] = 1'b0;
            host.done(row_lvl[i][3]);
            chk("in_service cleared", 16'h0, in_service);
        end
        irq_in[6] = 1'b1;
        take_chk(6, 8'h0e);
        host.done(1'b0);
        chk("edge not repended", 16'h0, pending);
        irq_in[6] = 1'b0;
        irq_in[4] = 1'b1;
        io(1'b1, CIR_SHARE_PORT_A | 12'h4, 1'b0);
        io(1'b1, CIR_SHARE_PORT_B | 12'h4, 1'b0);
        take_chk(4, 8'h0c);
        irq_in[4] = 1'b0;
        host.done(1'b0);
        chk("in_service after share", 16'h0, in_service);
        irq_in = 16'h0204;
        repeat (2) @(posedge sys_clk);
        #1;
        chk("masked lines", 16'h0, pending | {15'h0, int_req});
        irq_in = 16'h0000;
        casc = 1'b1;
        take_chk(9, CIR_REDIRECT_VEC);
        io(1'b0, CIR_LATCH_PORT, 1'b1);
        io(1'b0, CIR_LATCH_PORT, 1'b0);
        casc = 1'b0;
        host.done(1'b1);
        chk("in_service after cascade", 16'h0, in_service);
        irq_in[10] = 1'b1;
        take_chk(10, 8'h72);
        host.done(1'b1);
        chk("level repended", 16'h0400, pending & 16'h0400);
        irq_in[10] = 1'b0;
        rst_b = 1'b0;
        #2;
        chk("state in reset", 16'h0, in_service | pending | {15'h0, int_req});
        @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        @(posedge sys_clk);
        #1;
        chk("state after reset", 16'h0, in_service | pending | {15'h0, int_req});
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
